// ### rtl/pkg_state_map.svh
`ifndef PKG_STATE_MAP_SVH
`define PKG_STATE_MAP_SVH

// Bus clock period in ns
`define CLK_PERIOD_NS 100
// Stop-Grant entry limit after acknowledge response, bus clocks
`define STOP_GRANT_LIMIT_CLKS 20
// PLL settling after deep-sleep release, microseconds
`define PLL_SETTLE_US 15
`define PLL_SETTLE_CLKS ((`PLL_SETTLE_US * 1000) / `CLK_PERIOD_NS)
// Core unavailable time per frequency transition, microseconds
`define FREQ_BLOCK_US 10
`define FREQ_BLOCK_CLKS ((`FREQ_BLOCK_US * 1000) / `CLK_PERIOD_NS)
// Width of the voltage-select code
`define VSEL_W 7
`define FREQ_W 6
`define TIMER_W 12
// Reset value of operating point
`define VSEL_RESET 7'h20
`define FREQ_RESET 6'h08

`endif

// ### rtl/pkg_state_pkg.sv
package pkg_state_pkg;
  typedef enum logic [2:0] {
    PKG_NORMAL = 3'h0,
    PKG_STOP_GRANT = 3'h1,
    PKG_SG_SNOOP = 3'h2,
    PKG_SLEEP = 3'h3,
    PKG_DEEP_SLEEP = 3'h4,
    PKG_DEEP_EXIT = 3'h5
  } pkg_state_t;

  typedef enum logic [2:0] {
    CORE_C0 = 3'h0,
    CORE_C1 = 3'h1,
    CORE_C2 = 3'h2,
    CORE_C3 = 3'h3,
    CORE_SG = 3'h4
  } core_state_t;

  typedef enum logic [2:0] {
    PERF_IDLE = 3'h0,
    PERF_VUP = 3'h1,
    PERF_RELOCK = 3'h2,
    PERF_VDOWN = 3'h3
  } perf_state_t;
endpackage : pkg_state_pkg

// ### rtl/perf_coord.sv
`timescale 1ns/1ps
`default_nettype none
`include "pkg_state_map.svh"
module perf_coord
  import pkg_state_pkg::*;
#(
  parameter int VSEL_W = `VSEL_W,
  parameter int FREQ_W = `FREQ_W
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic core0_req_valid,
  input wire logic [FREQ_W-1:0] core0_req_freq,
  input wire logic [VSEL_W-1:0] core0_req_vsel,
  input wire logic core1_req_valid,
  input wire logic [FREQ_W-1:0] core1_req_freq,
  input wire logic [VSEL_W-1:0] core1_req_vsel,
  input wire logic pll_locked,
  output logic [VSEL_W-1:0] voltage_select_code,
  output logic [FREQ_W-1:0] pll_freq,
  output logic pll_relock,
  output logic block_next_request_n,
  output logic perf_busy
);
  localparam logic [11:0] BLOCK_CLKS = 12'(`FREQ_BLOCK_CLKS);

  perf_state_t st_r, st_nxt;
  logic [FREQ_W-1:0] c0f_r, c0f_nxt, c1f_r, c1f_nxt, curf_r, curf_nxt, tgtf_r, tgtf_nxt;
  logic [VSEL_W-1:0] c0v_r, c0v_nxt, c1v_r, c1v_nxt, curv_r, curv_nxt, tgtv_r, tgtv_nxt;
  logic pend_r, pend_nxt;
  logic [11:0] tmr_r, tmr_nxt;
  logic [FREQ_W-1:0] mf;
  logic [VSEL_W-1:0] mv;

  // Higher of two requests; equal requests fall through unchanged
  function automatic logic [FREQ_W-1:0] fmax(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
    fmax = (a > b) ? a : b;
  endfunction : fmax
  function automatic logic [VSEL_W-1:0] vmax(input logic [VSEL_W-1:0] a, input logic [VSEL_W-1:0] b);
    vmax = (a > b) ? a : b;
  endfunction : vmax

  always_comb
  begin
    mf = fmax(c0f_r, c1f_r);
    mv = vmax(c0v_r, c1v_r);
    st_nxt = st_r;
    c0f_nxt = core0_req_valid ? core0_req_freq : c0f_r;
    c0v_nxt = core0_req_valid ? core0_req_vsel : c0v_r;
    c1f_nxt = core1_req_valid ? core1_req_freq : c1f_r;
    c1v_nxt = core1_req_valid ? core1_req_vsel : c1v_r;
    curf_nxt = curf_r;
    curv_nxt = curv_r;
    tgtf_nxt = tgtf_r;
    tgtv_nxt = tgtv_r;
    tmr_nxt = tmr_r;
    // A new request during a transition waits here until idle
    pend_nxt = pend_r | core0_req_valid | core1_req_valid;
    case (st_r)
      PERF_IDLE:
      begin
        if (pend_r && (mf != curf_r || mv != curv_r))
        begin
          pend_nxt = core0_req_valid | core1_req_valid;
          tgtf_nxt = mf;
          tgtv_nxt = mv;
          st_nxt = (mf > curf_r) ? PERF_VUP : PERF_RELOCK;
        end
        else if (pend_r)
          pend_nxt = core0_req_valid | core1_req_valid;
      end
      PERF_VUP:
      begin
        // Step the code one at a time for a glitch-free ramp
        if (curv_r < tgtv_r)
          curv_nxt = curv_r + VSEL_W'(1);
        else
        begin
          tmr_nxt = BLOCK_CLKS;
          curf_nxt = tgtf_r;
          st_nxt = PERF_RELOCK;
        end
      end
      PERF_RELOCK:
      begin
        if (curf_r != tgtf_r)
        begin
          curf_nxt = tgtf_r;
          // The load cycle counts toward the blocked window
          tmr_nxt = BLOCK_CLKS - 12'h001;
        end
        else if (pll_locked || tmr_r == 12'h001)
        begin
          tmr_nxt = 12'h000;
          st_nxt = PERF_VDOWN;
        end
        else
          tmr_nxt = tmr_r - 12'h001;
      end
      PERF_VDOWN:
      begin
        if (curv_r > tgtv_r)
          curv_nxt = curv_r - VSEL_W'(1);
        else
        begin
          curv_nxt = tgtv_r;
          st_nxt = PERF_IDLE;
        end
      end
      default: st_nxt = PERF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= PERF_IDLE;
      c0f_r <= `FREQ_RESET;
      c1f_r <= `FREQ_RESET;
      curf_r <= `FREQ_RESET;
      tgtf_r <= `FREQ_RESET;
      c0v_r <= `VSEL_RESET;
      c1v_r <= `VSEL_RESET;
      curv_r <= `VSEL_RESET;
      tgtv_r <= `VSEL_RESET;
      pend_r <= 1'b0;
      tmr_r <= 12'h000;
    end
    else
    begin
      st_r <= st_nxt;
      c0f_r <= c0f_nxt;
      c1f_r <= c1f_nxt;
      curf_r <= curf_nxt;
      tgtf_r <= tgtf_nxt;
      c0v_r <= c0v_nxt;
      c1v_r <= c1v_nxt;
      curv_r <= curv_nxt;
      tgtv_r <= tgtv_nxt;
      pend_r <= pend_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign voltage_select_code = curv_r;
  assign pll_freq = curf_r;
  assign pll_relock = (st_r == PERF_RELOCK);
  assign block_next_request_n = ~(st_r == PERF_RELOCK);
  assign perf_busy = (st_r != PERF_IDLE);

  a_relock_bounded: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pll_relock) |-> ##[1:100] !pll_relock) else $error("Relock exceeded window");
  a_vup_before_lock: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == PERF_VUP) |=> (curf_r == $past(curf_r)) || st_r == PERF_RELOCK) else $error("Frequency moved early");
  a_bnr_during_lock: assert property (@(posedge clk) disable iff (!rstn)
    $changed(pll_freq) |-> !block_next_request_n) else $error("Frequency moved unblocked");
endmodule : perf_coord
`default_nettype wire

// ### rtl/pkg_power_seq.sv
// Contract
// - Any core in C0/C1 means Normal
// - Running cores enter Stop-Grant within 20 clocks
// - Stop-clock release restores prior core states
// - Reset in Stop-Grant keeps Stop-Grant state
// - Stop-Grant latches one interrupt per kind
// - Pending break asserts for any latched event, only while in Stop-Grant or Stop-Grant Snoop
// - Snoop or interrupt enters Stop-Grant Snoop
// - Sleep request in Stop-Grant enters Sleep
// - Reset in Sleep resets directly
// - Deep-sleep request enters and leaves Deep Sleep
// - Sleep counted after 15 us settling
// - Voltage up before relock, down after; a voltage rise without a frequency rise is applied after relock
// - Requests during transition are deferred
// - Cores blocked at most 10 us; a voltage-only change can block up to 4096 clocks
// - Merge core requests, take the higher
// - Package state resolved from core states
`timescale 1ns/1ps
`default_nettype none
`include "pkg_state_map.svh"
module pkg_power_seq
  import pkg_state_pkg::*;
#(
  parameter int VSEL_W = `VSEL_W,
  parameter int FREQ_W = `FREQ_W
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sys_reset_n,
  input wire logic stop_clock_request_n,
  input wire logic sleep_request_n,
  input wire logic deep_sleep_request_pin_n,
  input wire logic [2:0] core0_req_state,
  input wire logic [2:0] core1_req_state,
  input wire logic stop_grant_ack_resp,
  input wire logic bus_snoop,
  input wire logic bus_interrupt,
  input wire logic snoop_done,
  input wire logic system_mgmt_interrupt_n,
  input wire logic warm_restart_n,
  input wire logic [1:0] local_interrupt_lines,
  input wire logic monitor_event,
  input wire logic interrupt_enable_flag,
  input wire logic service_taken,
  input wire logic core0_req_valid,
  input wire logic [FREQ_W-1:0] core0_req_freq,
  input wire logic [VSEL_W-1:0] core0_req_vsel,
  input wire logic core1_req_valid,
  input wire logic [FREQ_W-1:0] core1_req_freq,
  input wire logic [VSEL_W-1:0] core1_req_vsel,
  input wire logic pll_locked,
  output logic [2:0] package_state,
  output logic [2:0] core0_state,
  output logic [2:0] core1_state,
  output logic pending_break_event_n,
  output logic internal_clk_run,
  output logic pll_enable,
  output logic core_init,
  output logic [3:0] latched_events,
  output logic [VSEL_W-1:0] voltage_select_code,
  output logic [FREQ_W-1:0] pll_freq,
  output logic pll_relock,
  output logic block_next_request_n,
  output logic perf_busy
);
  localparam logic [11:0] SETTLE_CLKS = 12'(`PLL_SETTLE_CLKS);

  pkg_state_t st_r, st_nxt;
  core_state_t c0_r, c0_nxt, c1_r, c1_nxt, c0_prev_r, c0_prev_nxt, c1_prev_r, c1_prev_nxt;
  logic [3:0] lat_r, lat_nxt;
  logic pbe_r, pbe_nxt;
  logic bint_r, bint_nxt;
  logic init_r, init_nxt;
  logic [11:0] tmr_r, tmr_nxt;
  logic [3:0] ev_in;
  logic in_sg;

  // Halt states count as running for package resolution
  function automatic logic core_active(input core_state_t s);
    core_active = (s == CORE_C0) || (s == CORE_C1);
  endfunction : core_active

  always_comb
  begin
    in_sg = (st_r == PKG_STOP_GRANT) || (st_r == PKG_SG_SNOOP);
    ev_in = {~local_interrupt_lines[1], ~local_interrupt_lines[0], ~warm_restart_n, ~system_mgmt_interrupt_n};
    st_nxt = st_r;
    c0_nxt = core_state_t'(core0_req_state);
    c1_nxt = core_state_t'(core1_req_state);
    c0_prev_nxt = c0_prev_r;
    c1_prev_nxt = c1_prev_r;
    lat_nxt = lat_r;
    bint_nxt = bint_r;
    tmr_nxt = tmr_r;
    init_nxt = 1'b0;
    // Reset from the system: Sleep resets fully, Stop-Grant stays put
    if (!sys_reset_n)
    begin
      init_nxt = 1'b1;
      lat_nxt = 4'h0;
      bint_nxt = 1'b0;
      c0_nxt = CORE_C0;
      c1_nxt = CORE_C0;
      if (in_sg)
      begin
        st_nxt = PKG_STOP_GRANT;
        c0_nxt = CORE_SG;
        c1_nxt = CORE_SG;
      end
      else
        st_nxt = PKG_NORMAL;
    end
    else
    begin
      if (!stop_clock_request_n && !(st_r == PKG_NORMAL && stop_grant_ack_resp == 1'b0))
      begin
        // Cores in C2/C3 keep their state; active ones park in Stop-Grant
        c0_nxt = core_active(c0_r) ? CORE_SG : c0_r;
        c1_nxt = core_active(c1_r) ? CORE_SG : c1_r;
        if (st_r == PKG_NORMAL)
        begin
          c0_prev_nxt = c0_r;
          c1_prev_nxt = c1_r;
        end
      end
      else if (c0_r == CORE_SG || c1_r == CORE_SG)
      begin
        if (stop_clock_request_n)
        begin
          c0_nxt = (c0_r == CORE_SG) ? c0_prev_r : c0_nxt;
          c1_nxt = (c1_r == CORE_SG) ? c1_prev_r : c1_nxt;
        end
        else
        begin
          c0_nxt = c0_r;
          c1_nxt = c1_r;
        end
      end
      // Latch events while stop-granted; set wins over service clear
      if (in_sg)
      begin
        lat_nxt = lat_r | ev_in;
        bint_nxt = bint_r | bus_interrupt;
      end
      else if (service_taken)
      begin
        lat_nxt = 4'h0;
        bint_nxt = 1'b0;
      end
      case (st_r)
        PKG_NORMAL:
          if (!stop_clock_request_n && !core_active(c0_nxt) && !core_active(c1_nxt))
            st_nxt = PKG_STOP_GRANT;
        PKG_STOP_GRANT:
          if (stop_clock_request_n)
            st_nxt = PKG_NORMAL;
          else if (!sleep_request_n)
            st_nxt = PKG_SLEEP;
          else if (bus_snoop || bus_interrupt)
            st_nxt = PKG_SG_SNOOP;
        PKG_SG_SNOOP:
          if (snoop_done)
            st_nxt = PKG_STOP_GRANT;
        PKG_SLEEP:
          if (!deep_sleep_request_pin_n)
            st_nxt = PKG_DEEP_SLEEP;
          else if (sleep_request_n)
            st_nxt = PKG_STOP_GRANT;
        PKG_DEEP_SLEEP:
          if (deep_sleep_request_pin_n)
          begin
            st_nxt = PKG_DEEP_EXIT;
            tmr_nxt = SETTLE_CLKS;
          end
        PKG_DEEP_EXIT:
          if (tmr_r == 12'h001)
            st_nxt = PKG_SLEEP;
          else
            tmr_nxt = tmr_r - 12'h001;
        default: st_nxt = PKG_NORMAL;
      endcase
      // Normal always wins while either core is active
      if (core_active(c0_nxt) || core_active(c1_nxt))
        st_nxt = PKG_NORMAL;
    end
    // A latched bus interrupt holds the break request whatever the enable flag says
    pbe_nxt = in_sg && ((|lat_nxt) || bint_nxt || monitor_event || (!interrupt_enable_flag && bus_interrupt));
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= PKG_NORMAL;
      c0_r <= CORE_C0;
      c1_r <= CORE_C0;
      c0_prev_r <= CORE_C0;
      c1_prev_r <= CORE_C0;
      lat_r <= 4'h0;
      pbe_r <= 1'b0;
      bint_r <= 1'b0;
      init_r <= 1'b0;
      tmr_r <= 12'h000;
    end
    else
    begin
      st_r <= st_nxt;
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
      c0_prev_r <= c0_prev_nxt;
      c1_prev_r <= c1_prev_nxt;
      lat_r <= lat_nxt;
      pbe_r <= pbe_nxt;
      bint_r <= bint_nxt;
      init_r <= init_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign package_state = st_r;
  assign core0_state = c0_r;
  assign core1_state = c1_r;
  assign pending_break_event_n = ~pbe_r;
  assign latched_events = lat_r;
  assign core_init = init_r;
  // Sleep stops internal clocks but keeps the PLL
  assign internal_clk_run = !(st_r == PKG_SLEEP || st_r == PKG_DEEP_SLEEP || st_r == PKG_DEEP_EXIT);
  assign pll_enable = (st_r != PKG_DEEP_SLEEP);

  perf_coord #(
    .VSEL_W(VSEL_W),
    .FREQ_W(FREQ_W)
  ) u_perf (
    .clk(clk),
    .rstn(rstn),
    .core0_req_valid(core0_req_valid),
    .core0_req_freq(core0_req_freq),
    .core0_req_vsel(core0_req_vsel),
    .core1_req_valid(core1_req_valid),
    .core1_req_freq(core1_req_freq),
    .core1_req_vsel(core1_req_vsel),
    .pll_locked(pll_locked),
    .voltage_select_code(voltage_select_code),
    .pll_freq(pll_freq),
    .pll_relock(pll_relock),
    .block_next_request_n(block_next_request_n),
    .perf_busy(perf_busy)
  );

  a_normal_active: assert property (@(posedge clk) disable iff (!rstn)
    sys_reset_n && (core_active(core_state_t'(core0_req_state)) && stop_clock_request_n) |=> st_r == PKG_NORMAL)
    else $error("Active core but not Normal");
  a_sg_entry: assert property (@(posedge clk) disable iff (!rstn)
    sys_reset_n && !stop_clock_request_n && stop_grant_ack_resp && c0_r == CORE_C0 ##1 !stop_clock_request_n
    |-> c0_r == CORE_SG) else $error("Core missed Stop-Grant");
  a_sg_return: assert property (@(posedge clk) disable iff (!rstn)
    sys_reset_n && stop_clock_request_n && c0_r == CORE_SG |=> c0_r == $past(c0_prev_r))
    else $error("Core not restored");
  a_reset_in_sg: assert property (@(posedge clk) disable iff (!rstn)
    !sys_reset_n && in_sg |=> st_r == PKG_STOP_GRANT && core_init) else $error("Reset left Stop-Grant");
  a_reset_in_sleep: assert property (@(posedge clk) disable iff (!rstn)
    !sys_reset_n && st_r == PKG_SLEEP |=> st_r == PKG_NORMAL) else $error("Sleep reset not direct");
  a_pbe_latched: assert property (@(posedge clk) disable iff (!rstn)
    in_sg && sys_reset_n && (|ev_in) && st_nxt != PKG_NORMAL |=> !pending_break_event_n)
    else $error("Pending break missing");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
    in_sg && sys_reset_n && !system_mgmt_interrupt_n |=> lat_r[0]) else $error("Event not latched");
  a_snoop_entry: assert property (@(posedge clk) disable iff (!rstn)
    sys_reset_n && st_r == PKG_STOP_GRANT && !stop_clock_request_n && sleep_request_n && bus_snoop
    && !core_active(core_state_t'(core0_req_state)) && !core_active(core_state_t'(core1_req_state))
    |=> st_r == PKG_SG_SNOOP) else $error("Snoop state missed");
  a_sleep_clocks: assert property (@(posedge clk) disable iff (!rstn)
    st_r == PKG_SLEEP |-> !internal_clk_run && pll_enable) else $error("Sleep clocks wrong");
  a_settle_time: assert property (@(posedge clk) disable iff (!rstn)
    st_r == PKG_DEEP_SLEEP ##1 st_r == PKG_DEEP_EXIT |-> tmr_r == SETTLE_CLKS) else $error("Settle count wrong");
endmodule : pkg_power_seq
`default_nettype wire

// ### bench/chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
module chipset_model
  import pkg_state_pkg::*;
(
  input wire logic clk,
  input wire logic [2:0] package_state,
  input wire logic pll_relock,
  output logic sys_reset_n,
  output logic stop_clock_request_n,
  output logic sleep_request_n,
  output logic deep_sleep_request_pin_n,
  output logic pll_locked
);
  int lock_wait = 3;
  int lock_cnt = 0;

  initial
  begin
    {sys_reset_n, stop_clock_request_n, sleep_request_n, deep_sleep_request_pin_n} = 4'hF;
  end

  // Lock drops during relock; waits of 100 cycles or more push the design onto its timeout path
  always @(negedge clk)
  begin
    lock_cnt = (pll_relock === 1'h1) ? lock_cnt + 1 : 0;
    pll_locked = (lock_cnt == 0) || (lock_cnt > lock_wait);
  end

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  task automatic stop_on();
    stop_clock_request_n = 1'h0;
  endtask : stop_on

  task automatic sleep_on();
    for (int i = 0; i < 50 && package_state !== PKG_STOP_GRANT; i++)
      step(1);
    sleep_request_n = 1'h0;
    step(1);
  endtask : sleep_on

  // Bus clock keeps running in Deep Sleep, which is allowed; all other pins stay put
  task automatic deep(input logic lvl);
    deep_sleep_request_pin_n = lvl;
    step(1);
  endtask : deep

  // Sleep released before stop-clock on the way out
  task automatic wake();
    sleep_request_n = 1'h1;
    step(2);
    stop_clock_request_n = 1'h1;
    step(2);
  endtask : wake

  task automatic reset_on();
    sys_reset_n = 1'h0;
    step(1);
  endtask : reset_on

  task automatic reset_off();
    {stop_clock_request_n, sleep_request_n, deep_sleep_request_pin_n} = 3'h7;
    step(2);
    sys_reset_n = 1'h1;
    step(2);
  endtask : reset_off
endmodule : chipset_model
`default_nettype wire

// ### bench/test_package_low_power_state_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_package_low_power_state_sequencer;
  import pkg_state_pkg::*;
  logic clk, rstn, sys_reset_n, stop_clock_request_n, sleep_request_n, deep_sleep_request_pin_n, pll_locked;
  logic [2:0] core0_req_state, core1_req_state, package_state, core0_state, core1_state;
  logic stop_grant_ack_resp, bus_snoop, bus_interrupt, snoop_done, system_mgmt_interrupt_n, warm_restart_n;
  logic [1:0] local_interrupt_lines;
  logic monitor_event, interrupt_enable_flag, service_taken, core0_req_valid, core1_req_valid;
  logic [5:0] core0_req_freq, core1_req_freq, pll_freq, tgt_f, cur_f, a, b;
  logic [6:0] core0_req_vsel, core1_req_vsel, voltage_select_code, tgt_v, cur_v;
  logic pending_break_event_n, internal_clk_run, pll_enable, core_init, pll_relock, block_next_request_n, perf_busy;
  logic [3:0] latched_events, ev;
  logic rl_q = 1'h0;
  logic mon_en = 1'h0;
  int err_count = 0;
  int comparisons = 0;
  int n, bnr_cnt = 0;

  pkg_power_seq i_pkg_power_seq (.clk, .rstn, .sys_reset_n, .stop_clock_request_n, .sleep_request_n,
    .deep_sleep_request_pin_n, .core0_req_state, .core1_req_state, .stop_grant_ack_resp, .bus_snoop,
    .bus_interrupt, .snoop_done, .system_mgmt_interrupt_n, .warm_restart_n, .local_interrupt_lines,
    .monitor_event, .interrupt_enable_flag, .service_taken, .core0_req_valid, .core0_req_freq,
    .core0_req_vsel, .core1_req_valid, .core1_req_freq, .core1_req_vsel, .pll_locked, .package_state,
    .core0_state, .core1_state, .pending_break_event_n, .internal_clk_run, .pll_enable, .core_init,
    .latched_events, .voltage_select_code, .pll_freq, .pll_relock, .block_next_request_n, .perf_busy);

  chipset_model i_chipset_model (.clk, .package_state, .pll_relock, .sys_reset_n, .stop_clock_request_n,
    .sleep_request_n, .deep_sleep_request_pin_n, .pll_locked);

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse

  // Voltage rises with frequency so the two merged maxima stay consistent
  function automatic logic [6:0] vmap(input logic [5:0] f);
    return {1'h0, f} + 7'h18;
  endfunction : vmap

  task automatic perf(input logic [5:0] f0, input logic [5:0] f1);
    {core0_req_freq, core1_req_freq} = {f0, f1};
    {core0_req_vsel, core1_req_vsel} = {vmap(f0), vmap(f1)};
    tgt_f = (f0 > f1) ? f0 : f1;
    tgt_v = vmap(tgt_f);
    {core0_req_valid, core1_req_valid} = 2'h3;
    cyc(1);
    {core0_req_valid, core1_req_valid} = 2'h0;
  endtask : perf

  task automatic wait_idle();
    n = 0;
    for (int i = 0; i < 900 && n < 4; i++)
    begin
      cyc(1);
      n = (perf_busy === 1'h0) ? n + 1 : 0;
    end
    check(n, 4);
  endtask : wait_idle

  task automatic sg_on();
    {core0_req_state, core1_req_state} = {CORE_C0, CORE_C2};
    cyc(2);
    i_chipset_model.stop_on();
    pulse(stop_grant_ack_resp);
    check(core0_state, CORE_SG);
    check(core1_state, CORE_C2);
    check(package_state, PKG_STOP_GRANT);
  endtask : sg_on

  always @(negedge clk)
  begin
    if (mon_en && pll_relock === 1'h1 && !rl_q)
    begin
      check(voltage_select_code, (tgt_f > cur_f) ? tgt_v : cur_v);
      check(block_next_request_n, 1'h0);
    end
    bnr_cnt = (block_next_request_n === 1'h0) ? bnr_cnt + 1 : 0;
    if (bnr_cnt == 101)
      check(bnr_cnt, 100);
    rl_q = (pll_relock === 1'h1);
  end

  initial
  begin
    #2000000;
    err_count++;
    end_sim();
  end

  initial
  begin
    rstn = 1'h0;
    {core0_req_state, core1_req_state} = 6'h0;
    {stop_grant_ack_resp, bus_snoop, bus_interrupt, snoop_done, monitor_event, service_taken} = 6'h0;
    {local_interrupt_lines, warm_restart_n, system_mgmt_interrupt_n} = 4'hF;
    interrupt_enable_flag = 1'h1;
    {core0_req_valid, core1_req_valid} = 2'h0;
    {core0_req_freq, core1_req_freq} = {6'h08, 6'h08};
    {core0_req_vsel, core1_req_vsel} = {7'h20, 7'h20};
    void'($urandom(49));
    cyc(4);
    rstn = 1'h1;
    cyc(1);
    check(package_state, PKG_NORMAL);
    check(pending_break_event_n, 1'h1);
    check(latched_events, 4'h0);
    check({voltage_select_code, pll_freq}, {7'h20, 6'h08});
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      {core1_req_state, core0_req_state} = {1'h0, i[3:2], 1'h0, i[1:0]};
      cyc(2);
      if (i[1:0] < 2 || i[3:2] < 2)
        check(package_state, PKG_NORMAL);
    end
    $display("test normal done");
    sg_on();
    pulse(monitor_event);
    check(pending_break_event_n, 1'h0);
    interrupt_enable_flag = 1'h0;
    for (int j = 0; j < 2; j++)
    begin
      {bus_interrupt, bus_snoop} = 2'h1 << j;
      cyc(1);
      {bus_interrupt, bus_snoop} = 2'h0;
      check(package_state, PKG_SG_SNOOP);
      pulse(snoop_done);
      check(package_state, PKG_STOP_GRANT);
      check(pending_break_event_n, j == 0);
    end
    interrupt_enable_flag = 1'h1;
    ev = 4'h0;
    for (int k = 0; k < 4; k++)
    begin
      {local_interrupt_lines, warm_restart_n, system_mgmt_interrupt_n} = ~(4'h1 << k);
      cyc(1);
      {local_interrupt_lines, warm_restart_n, system_mgmt_interrupt_n} = 4'hF;
      ev[k] = 1'h1;
      cyc(1);
      check(latched_events, ev);
      check(pending_break_event_n, 1'h0);
    end
    // Host bus stays quiet from here until back in Stop-Grant
    i_chipset_model.sleep_on();
    check(package_state, PKG_SLEEP);
    check({internal_clk_run, pll_enable}, 2'h1);
    i_chipset_model.deep(1'h0);
    check(package_state, PKG_DEEP_SLEEP);
    i_chipset_model.deep(1'h1);
    check(package_state, PKG_DEEP_EXIT);
    n = 0;
    while (package_state !== PKG_SLEEP && n < 200)
    begin
      cyc(1);
      n++;
    end
    check(n >= 150 && n <= 153, 1'h1);
    i_chipset_model.wake();
    check({core0_state, core1_state}, {CORE_C0, CORE_C2});
    check(package_state, PKG_NORMAL);
    pulse(service_taken);
    cyc(1);
    check({latched_events, pending_break_event_n}, 5'h01);
    $display("test low power walk done");
    sg_on();
    i_chipset_model.reset_on();
    cyc(1);
    check({core_init, package_state}, {1'h1, PKG_STOP_GRANT});
    i_chipset_model.reset_off();
    sg_on();
    i_chipset_model.sleep_on();
    i_chipset_model.reset_on();
    check(package_state, PKG_NORMAL);
    i_chipset_model.reset_off();
    $display("test reset in low power done");
    mon_en = 1'h1;
    {cur_f, cur_v} = {6'h08, 7'h20};
    for (int i = 0; i < 12; i++)
    begin
      i_chipset_model.lock_wait = $urandom_range(130, 1);
      a = (i == 0) ? 6'h3F : 6'($urandom);
      b = (i < 2) ? 6'h00 : ((i % 3 == 0) ? a : 6'($urandom));
      perf(a, b);
      wait_idle();
      check({voltage_select_code, pll_freq}, {tgt_v, tgt_f});
      check({pll_relock, block_next_request_n}, 2'h1);
      {cur_f, cur_v} = {tgt_f, tgt_v};
    end
    mon_en = 1'h0;
    perf(6'h00, 6'h00);
    wait_idle();
    perf(6'h3F, 6'h3F);
    cyc(3);
    check(perf_busy, 1'h1);
    perf(6'h01, 6'h02);
    wait_idle();
    check({voltage_select_code, pll_freq}, {vmap(6'h02), 6'h02});
    $display("test performance done");
    end_sim();
  end
endmodule : test_package_low_power_state_sequencer
`default_nettype wire
